// ### src/cdp_pkg.sv
//*********************************************************
// Overview of operation
//*********************************************************
package cdp_pkg;
    typedef enum logic [1:0] {
        CDP_MODE_PS  = 2'h0,
        CDP_MODE_FPP = 2'h1,
        CDP_MODE_AS  = 2'h2
    } cdp_mode_t;

    typedef enum logic [3:0] {
        CDP_ST_IDLE = 4'h1,
        CDP_ST_LOAD = 4'h2,
        CDP_ST_DONE = 4'h4,
        CDP_ST_ERR  = 4'h8
    } cdp_state_t;

    typedef struct packed {
        logic       is_last;
        logic [7:0] data;
    } cdp_word_t;

    localparam int unsigned CDP_CLK_HZ      = 20000000;
    localparam int unsigned CDP_AS_CLK_HZ   = 5000000;
    localparam int unsigned CDP_AS_DIV      = CDP_CLK_HZ / (2 * CDP_AS_CLK_HZ);
    localparam logic [7:0]  CDP_AS_READ_CMD = 8'h03;
    localparam int unsigned CDP_AS_ADDR_W   = 24;
    localparam int unsigned CDP_DEF_BYTES   = 16;
endpackage : cdp_pkg

// ### src/cdp_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module cdp_fifo #(
    parameter int unsigned W = 9,
    parameter int unsigned D = 32
) (
    input  wire logic         clk_sys,
    input  wire logic         srst,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output var  logic         in_ready,
    output var  logic [W-1:0] out_data,
    output var  logic         out_valid,
    input  wire logic         out_ready
);
    localparam int unsigned AW = $clog2(D);
    logic [W-1:0] mem_reg [D];
    logic [AW:0]  wr_reg;
    logic [AW:0]  rd_reg;
    logic         push;
    logic         pop;
    assign in_ready  = (wr_reg - rd_reg) != (AW+1)'(D);
    assign out_valid = wr_reg != rd_reg;
    assign out_data  = mem_reg[rd_reg[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_reg[wr_reg[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            wr_reg <= wr_reg + (AW+1)'(push);
            rd_reg <= rd_reg + (AW+1)'(pop);
        end
    end
endmodule : cdp_fifo
`default_nettype wire

// ### src/cdp_top.sv
`timescale 1ns/1ps
`default_nettype none
module cdp_top #(
    parameter int unsigned LOAD_BYTES = cdp_pkg::CDP_DEF_BYTES,
    parameter bit          BIT0_USER  = 1'b0
) (
    input  wire logic              clk_sys,
    input  wire logic              srst,
    input  wire logic              config_clock_in,
    output logic                   config_clock_out,
    output logic                   config_clock_oe,
    input  wire logic              chain_sel_n,
    output logic                   chain_out_n,
    output logic                   chain_out_oe,
    input  wire logic [7:0]        config_data_in,
    output logic                   config_data_oe,
    output logic                   serial_mem_cmd_out,
    output logic                   serial_mem_select_n,
    input  wire logic [1:0]        mode_sel,
    input  wire logic              start_cfg,
    input  wire logic              user_chain_out,
    input  wire logic              user_chain_oe,
    input  wire logic              user_data_oe,
    output logic                   config_complete_flag,
    output logic                   status_oe,
    output logic [7:0]             load_byte,
    output logic                   load_valid,
    input  wire logic              load_ready
);
    //*********************************************************
    // Pin synchronisers on the system clock
    //*********************************************************
    logic [1:0] csel_s_reg;
    logic [1:0] mode_s0_reg;
    logic [1:0] mode_s1_reg;
    logic [1:0] start_s_reg;
    logic [7:0] asd_s0_reg;
    logic [7:0] asd_s1_reg;
    always_ff @(posedge clk_sys) begin
        csel_s_reg  <= {csel_s_reg[0], chain_sel_n};
        mode_s0_reg <= mode_sel;
        mode_s1_reg <= mode_s0_reg;
        start_s_reg <= {start_s_reg[0], start_cfg};
        asd_s0_reg  <= config_data_in;
        asd_s1_reg  <= asd_s0_reg;
    end
    cdp_pkg::cdp_mode_t  mode;
    cdp_pkg::cdp_state_t st_reg;
    logic                enabled;
    assign mode    = cdp_pkg::cdp_mode_t'(mode_s1_reg);
    assign enabled = !csel_s_reg[1];

    //*********************************************************
    // Link domain: capture on the external configuration clock
    //*********************************************************
    // Only used in passive modes; the clock may stop between frames, so the
    // link side holds no handshake state, just a byte and a toggle.
    logic       lk_en_s0_reg;
    logic       lk_en_reg;
    logic       lk_fpp_s0_reg;
    logic       lk_fpp_reg;
    logic [7:0] lk_shift_reg;
    logic [2:0] lk_cnt_reg;
    logic [7:0] lk_byte_reg;
    logic       lk_tog_reg;
    logic       load_active_reg;
    always_ff @(posedge config_clock_in) begin
        lk_en_s0_reg  <= load_active_reg && mode != cdp_pkg::CDP_MODE_AS;
        lk_en_reg     <= lk_en_s0_reg;
        lk_fpp_s0_reg <= mode == cdp_pkg::CDP_MODE_FPP;
        lk_fpp_reg    <= lk_fpp_s0_reg;
    end
    always_ff @(posedge config_clock_in) begin
        if (lk_en_reg && !chain_sel_n) begin
            if (lk_fpp_reg) begin
                lk_byte_reg <= config_data_in;
                lk_tog_reg  <= !lk_tog_reg;
                lk_cnt_reg  <= 3'h0;
            end else begin
                lk_shift_reg <= {lk_shift_reg[6:0], config_data_in[0]};
                lk_cnt_reg   <= lk_cnt_reg + 3'h1;
                if (lk_cnt_reg == 3'h7) begin
                    lk_byte_reg <= {lk_shift_reg[6:0], config_data_in[0]};
                    lk_tog_reg  <= !lk_tog_reg;
                end
            end
        end else begin
            // Clearing the toggle while idle gives it a known value with no reset.
            lk_cnt_reg <= 3'h0;
            lk_tog_reg <= 1'b0;
        end
    end
    // The byte register is stable for many system clocks after each toggle.
    logic [2:0] tog_s_reg;
    logic       ps_evt;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            tog_s_reg <= 3'h0;
        end else begin
            tog_s_reg <= {tog_s_reg[1:0], lk_tog_reg};
        end
    end
    assign ps_evt = tog_s_reg[2] ^ tog_s_reg[1];

    //*********************************************************
    // Active serial master
    //*********************************************************
    logic [7:0]  div_reg;
    logic        sck_reg;
    logic [5:0]  as_bit_reg;
    logic [31:0] as_cmd_reg;
    logic [7:0]  as_shift_reg;
    logic [2:0]  as_cnt_reg;
    logic        as_evt_reg;
    logic        as_run;
    logic        rise;
    logic        fall;
    assign as_run = load_active_reg && mode == cdp_pkg::CDP_MODE_AS && enabled;
    assign rise   = as_run && !sck_reg && div_reg == 8'(cdp_pkg::CDP_AS_DIV - 1);
    assign fall   = as_run && sck_reg && div_reg == 8'(cdp_pkg::CDP_AS_DIV - 1);
    always_ff @(posedge clk_sys) begin
        if (srst || !as_run) begin
            div_reg <= 8'h0;
            sck_reg <= 1'b1;
        end else if (div_reg == 8'(cdp_pkg::CDP_AS_DIV - 1)) begin
            div_reg <= 8'h0;
            sck_reg <= !sck_reg;
        end else begin
            div_reg <= div_reg + 8'h1;
        end
    end
    always_ff @(posedge clk_sys) begin
        as_evt_reg <= 1'b0;
        if (srst || !as_run) begin
            as_cmd_reg   <= {cdp_pkg::CDP_AS_READ_CMD, 24'h0};
            as_bit_reg   <= 6'h0;
            as_cnt_reg   <= 3'h0;
            as_shift_reg <= 8'h0;
        end else begin
            if (fall && as_bit_reg != 6'h0) begin
                as_cmd_reg <= {as_cmd_reg[30:0], 1'b0};
            end
            if (rise) begin
                if (as_bit_reg < 6'd32) begin
                    as_bit_reg <= as_bit_reg + 6'h1;
                end else begin
                    as_shift_reg <= {as_shift_reg[6:0], asd_s1_reg[0]};
                    as_cnt_reg   <= as_cnt_reg + 3'h1;
                    as_evt_reg   <= as_cnt_reg == 3'h7;
                end
            end
        end
    end

    //*********************************************************
    // Load control
    //*********************************************************
    logic [15:0]      byte_cnt_reg;
    logic             fifo_ready;
    logic             byte_evt;
    logic [7:0]       byte_val;
    cdp_pkg::cdp_word_t fifo_in;
    cdp_pkg::cdp_word_t fifo_out;
    logic             fifo_out_valid;
    assign byte_evt      = ps_evt || as_evt_reg;
    assign byte_val      = as_evt_reg ? as_shift_reg : lk_byte_reg;
    assign fifo_in.data  = byte_val;
    assign fifo_in.is_last = byte_cnt_reg == 16'(LOAD_BYTES - 1);
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_reg       <= cdp_pkg::CDP_ST_IDLE;
            byte_cnt_reg <= 16'h0;
        end else begin
            case (st_reg)
                cdp_pkg::CDP_ST_IDLE: begin
                    byte_cnt_reg <= 16'h0;
                    if (start_s_reg[1] && enabled) begin
                        st_reg <= cdp_pkg::CDP_ST_LOAD;
                    end
                end
                cdp_pkg::CDP_ST_LOAD: begin
                    if (byte_evt) begin
                        if (!fifo_ready || !enabled) begin
                            st_reg <= cdp_pkg::CDP_ST_ERR;
                        end else if (fifo_in.is_last) begin
                            st_reg <= cdp_pkg::CDP_ST_DONE;
                        end
                        byte_cnt_reg <= byte_cnt_reg + 16'h1;
                    end
                end
                cdp_pkg::CDP_ST_DONE: st_reg <= cdp_pkg::CDP_ST_DONE;
                cdp_pkg::CDP_ST_ERR:  st_reg <= cdp_pkg::CDP_ST_ERR;
                default:              st_reg <= cdp_pkg::CDP_ST_IDLE;
            endcase
        end
    end
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            load_active_reg <= 1'b0;
        end else begin
            load_active_reg <= st_reg == cdp_pkg::CDP_ST_LOAD;
        end
    end
    cdp_fifo #(
        .W (9),
        .D (32)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .in_data   (fifo_in),
        .in_valid  (byte_evt && st_reg == cdp_pkg::CDP_ST_LOAD && enabled),
        .in_ready  (fifo_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_out_valid),
        .out_ready (load_ready && !load_valid)
    );

    //*********************************************************
    // Output registers
    //*********************************************************
    logic done;
    assign done = st_reg == cdp_pkg::CDP_ST_DONE;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            load_byte            <= 8'h0;
            load_valid           <= 1'b0;
            config_complete_flag <= 1'b0;
            status_oe            <= 1'b0;
            chain_out_n          <= 1'b1;
            chain_out_oe         <= 1'b0;
            config_data_oe       <= 1'b0;
            serial_mem_cmd_out   <= 1'b1;
            serial_mem_select_n  <= 1'b1;
            config_clock_out     <= 1'b1;
            config_clock_oe      <= 1'b0;
        end else begin
            load_valid <= fifo_out_valid && load_ready && !load_valid;
            if (fifo_out_valid && load_ready && !load_valid) begin
                load_byte <= fifo_out.data;
            end
            config_complete_flag <= done;
            status_oe            <= st_reg == cdp_pkg::CDP_ST_ERR;
            chain_out_n          <= done ? user_chain_out : 1'b1;
            chain_out_oe         <= done ? user_chain_oe : 1'b1;
            config_data_oe       <= done && user_data_oe;
            serial_mem_cmd_out   <= as_run ? as_cmd_reg[31] : 1'b1;
            serial_mem_select_n  <= !as_run;
            config_clock_out     <= as_run ? sck_reg : 1'b1;
            config_clock_oe      <= mode == cdp_pkg::CDP_MODE_AS && !done;
        end
    end

    //*********************************************************
    // Checks
    //*********************************************************
    chain_done_a: assert property (@(posedge clk_sys) disable iff (srst)
        $rose(done) |=> !chain_out_n || !chain_out_oe || user_chain_out)
        else $error("Chain output not released after done.");
    accept_sel_a: assert property (@(posedge clk_sys) disable iff (srst)
        (st_reg == cdp_pkg::CDP_ST_IDLE && !enabled) |=> st_reg != cdp_pkg::CDP_ST_LOAD)
        else $error("Load started with chain select high.");
    done_flag_a: assert property (@(posedge clk_sys) disable iff (srst)
        st_reg == cdp_pkg::CDP_ST_LOAD |=> !config_complete_flag)
        else $error("Done flag raised during load.");
    err_status_a: assert property (@(posedge clk_sys) disable iff (srst)
        st_reg == cdp_pkg::CDP_ST_ERR |=> status_oe)
        else $error("Error not signalled on status line.");
    mem_select_a: assert property (@(posedge clk_sys) disable iff (srst)
        as_run |=> !serial_mem_select_n)
        else $error("Memory select not driven during active serial.");
    done_stays_a: assert property (@(posedge clk_sys) disable iff (srst)
        done |=> done [*3])
        else $error("Configured state changed.");
    clk_idle_a: assert property (@(posedge clk_sys) disable iff (srst)
        done ##1 done |=> config_clock_out && !config_clock_oe)
        else $error("Clock pin not inactive after configuration.");
    data_hiz_a: assert property (@(posedge clk_sys) disable iff (srst)
        !done |=> !config_data_oe)
        else $error("Data pins driven during configuration.");
    ignore_sel_a: assert property (@(posedge clk_sys) disable iff (srst)
        !enabled |-> !as_run)
        else $error("Active serial running with chain select high.");
endmodule : cdp_top
`default_nettype wire

// ### sim/cdp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cdp_host_model (
    output var logic       config_clock_in,
    output var logic [7:0] config_data_in
);
    initial begin
        config_clock_in = 1'b0;
        config_data_in  = 8'h00;
    end

    task automatic pulse();
        #3 config_clock_in = 1'b1;
        #3 config_clock_in = 1'b0;
    endtask : pulse

    // Two clocks that carry the start enable across into the link domain.
    task automatic preamble();
        #1.7;
        pulse();
        pulse();
        #300;
    endtask : preamble

    task automatic send_byte(input logic [7:0] b, input bit par);
        #1.3;
        if (par) begin
            config_data_in = b;
            pulse();
        end else begin
            for (int i = 7; i >= 0; i--) begin
                config_data_in[0]   = b[i];
                config_data_in[7:1] = ~config_data_in[7:1];
                pulse();
            end
        end
        // Released pins never keep their last value, so stale data cannot match.
        config_data_in = ~config_data_in;
        #300;
    endtask : send_byte
endmodule : cdp_host_model
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int unsigned NB = 36;
    logic       clk_sys, srst, chain_sel_n, start_cfg, load_ready;
    logic       user_chain_out, user_chain_oe, user_data_oe;
    logic [1:0] mode_sel;
    logic       config_clock_in, config_clock_out, config_clock_oe, chain_out_n, chain_out_oe;
    logic [7:0] config_data_in, load_byte;
    logic       config_data_oe, serial_mem_cmd_out, serial_mem_select_n;
    logic       config_complete_flag, status_oe, load_valid;
    logic [7:0] got_q[$];
    int         n_fail, cmp_count, cyc;

    cdp_host_model host (.config_clock_in(config_clock_in), .config_data_in(config_data_in));

    cdp_top #(.LOAD_BYTES(NB)) DUT (
        .clk_sys(clk_sys), .srst(srst), .config_clock_in(config_clock_in),
        .config_clock_out(config_clock_out), .config_clock_oe(config_clock_oe),
        .chain_sel_n(chain_sel_n), .chain_out_n(chain_out_n), .chain_out_oe(chain_out_oe),
        .config_data_in(config_data_in), .config_data_oe(config_data_oe),
        .serial_mem_cmd_out(serial_mem_cmd_out), .serial_mem_select_n(serial_mem_select_n),
        .mode_sel(mode_sel), .start_cfg(start_cfg), .user_chain_out(user_chain_out),
        .user_chain_oe(user_chain_oe), .user_data_oe(user_data_oe),
        .config_complete_flag(config_complete_flag), .status_oe(status_oe),
        .load_byte(load_byte), .load_valid(load_valid), .load_ready(load_ready));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        if (load_valid === 1'b1) got_q.push_back(load_byte);
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            n_fail++;
            final_report();
        end
    end

    function automatic logic [7:0] pat(input int i);
        return 8'((i * 37) ^ 8'ha6);
    endfunction : pat

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check

    task automatic do_reset(input logic [1:0] m);
        srst      <= 1'b1;
        start_cfg <= 1'b0;
        mode_sel  <= m;
        host.pulse();
        host.pulse();
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        check(chain_out_n, 1'b1, "chain out idle");
        check(config_complete_flag, 1'b0, "done at reset");
    endtask : do_reset

    // Host holds select at the given level for the whole load.
    task automatic load(input logic [1:0] m, input bit par, input logic sel_n, input logic rdy);
        do_reset(m);
        chain_sel_n <= sel_n;
        load_ready  <= rdy;
        got_q.delete();
        start_cfg <= 1'b1;
        repeat (4) @(posedge clk_sys);
        host.preamble();
        for (int i = 0; i < NB; i++) host.send_byte(pat(i), par);
        repeat (40) @(posedge clk_sys);
    endtask : load

    task automatic good_loads();
        for (int k = 0; k < 2; k++) begin
            load(k[1:0], k[0], 1'b0, 1'b1);
            check(got_q.size(), NB, "byte count");
            for (int i = 0; i < NB && i < got_q.size(); i++) check(got_q[i], pat(i), "byte");
            check(config_complete_flag, 1'b1, "done flag");
            check(chain_out_n, 1'b0, "chain out after done");
            check(chain_out_oe, user_chain_oe, "chain oe user");
            check(config_data_oe, user_data_oe, "data oe user");
            check(config_clock_oe, 1'b0, "clock not driven");
            check(status_oe, 1'b0, "no error");
            host.send_byte(8'h11, k[0]);
            repeat (20) @(posedge clk_sys);
            check(got_q.size(), NB, "clock after done");
        end
    endtask : good_loads

    task automatic overflow_load();
        load(cdp_pkg::CDP_MODE_FPP, 1'b1, 1'b0, 1'b0);
        check(status_oe, 1'b1, "overflow error");
        check(config_complete_flag, 1'b0, "no done on error");
        load_ready <= 1'b1;
        repeat (80) @(posedge clk_sys);
        check(status_oe, 1'b1, "error holds");
    endtask : overflow_load

    task automatic deselected_load();
        load(cdp_pkg::CDP_MODE_PS, 1'b0, 1'b1, 1'b1);
        check(got_q.size(), 0, "bytes while deselected");
        check(config_complete_flag, 1'b0, "done while deselected");
    endtask : deselected_load

    task automatic active_serial();
        logic [31:0] cmd;
        int          w;
        do_reset(cdp_pkg::CDP_MODE_AS);
        chain_sel_n <= 1'b0;
        start_cfg   <= 1'b1;
        for (int k = 31; k >= 0; k--) begin
            w = 0;
            while (config_clock_out !== 1'b0 && w < 40) begin
                @(posedge clk_sys);
                w++;
            end
            while (config_clock_out !== 1'b1 && w < 40) begin
                @(posedge clk_sys);
                w++;
            end
            cmd[k] = serial_mem_cmd_out;
            if (k == 31) check(config_clock_oe, 1'b1, "clock driven");
            if (k == 31) check(serial_mem_select_n, 1'b0, "memory select");
        end
        check(cmd, {cdp_pkg::CDP_AS_READ_CMD, 24'h000000}, "read command");
    endtask : active_serial

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    initial begin
        n_fail = 0;
        cmp_count = 0;
        cyc = 0;
        srst = 1'b1;
        start_cfg = 1'b0;
        chain_sel_n = 1'b0;
        load_ready = 1'b1;
        mode_sel = 2'h0;
        user_chain_out = 1'b0;
        user_chain_oe = 1'b1;
        user_data_oe = 1'b1;
        good_loads();
        overflow_load();
        deselected_load();
        active_serial();
        final_report();
    end
endmodule : tb_top
`default_nettype wire
